// File: hdl/audio_output_routing_control.sv
// Audio output routing control: registers, auto-mute, level trim, DAC and analog output routing.
`default_nettype none
`include "audio_routing_params.svh"

// Summary of operation
// - Broadcast trim: 1 dB steps, bit4 attenuates
// - Error count below lower: reselect broadcast
// - Error count above upper: switch to fallback
// - Between thresholds: keep current selection
// - Lower threshold resets to 0x14
// - Upper threshold resets to 0x50
// - Mute bits 6 and 2 silence pairs
// - Mute register resets all ones
// - DAC gain adds 0, 3, 6, 9 dB
// - DAC source code routes FM, broadcast, M1, M2
// - Matrix codes map L/R, L/L, R/R, R/L, average
// - Average only for DAC-derived signal
// - Analog source: DAC, external, mono input
// - Analog input selected mutes DAC outputs
// - Auto-switch only when enabled and digital mode
// - Fallback pick plus DAC selects mono input
// - Serial output always falls back to FM
module audio_output_routing_control
  import audio_routing_pkg::*;
#(
  parameter int SW         = 16,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_rst_n,
  // Register access by subaddress
  input  wire logic          i_reg_wr,
  input  wire logic          i_reg_rd,
  input  wire logic [7:0]    i_reg_addr,
  input  wire logic [7:0]    i_reg_wdata,
  output logic      [7:0]    o_reg_rdata,
  output logic               o_reg_ack,
  // Demodulator status and configuration
  input  wire logic          i_err_valid,
  input  wire logic [7:0]    i_err_count,
  input  wire logic          i_auto_switch_disable,
  input  wire logic          i_fallback_source_pick,
  input  wire logic          i_carrier2_digital,
  // Input sample frames
  input  wire logic          i_in_valid,
  output logic               o_in_ready,
  input  wire logic [SW-1:0] i_in_fm_left,
  input  wire logic [SW-1:0] i_in_fm_right,
  input  wire logic [SW-1:0] i_in_bc_left,
  input  wire logic [SW-1:0] i_in_bc_right,
  // Output sample frames
  output logic               o_out_valid,
  input  wire logic          i_out_ready,
  output logic      [SW-1:0] o_ser_left,
  output logic      [SW-1:0] o_ser_right,
  output logic      [SW-1:0] o_dac_left,
  output logic      [SW-1:0] o_dac_right,
  // Analog switch controls and status
  output logic      [1:0]    o_analog_source,
  output logic      [2:0]    o_analog_matrix,
  output logic               o_dac_mute,
  output logic               o_serial_mute,
  output logic               o_analog_mute,
  output logic               o_broadcast_selected
);

  localparam int FW = 4 * SW;
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // --------------------------------------------------------------------------
  // Gain tables
  // --------------------------------------------------------------------------
  function automatic logic [12:0] trim_factor(input logic [4:0] code);
    logic [12:0] f;
    f = `AR_GAIN_UNITY;
    unique case (code)
      5'h00: f = 13'h0400; 5'h01: f = 13'h047D; 5'h02: f = 13'h0509; 5'h03: f = 13'h05A6;
      5'h04: f = 13'h0657; 5'h05: f = 13'h071D; 5'h06: f = 13'h07FB; 5'h07: f = 13'h08F4;
      5'h08: f = 13'h0A0C; 5'h09: f = 13'h0B46; 5'h0A: f = 13'h0CA6; 5'h0B: f = 13'h0E31;
      5'h0C: f = 13'h0FED; 5'h0D: f = 13'h11DE; 5'h0E: f = 13'h140C; 5'h0F: f = 13'h167E;
      5'h10: f = 13'h00B6; 5'h11: f = 13'h00CC; 5'h12: f = 13'h00E5; 5'h13: f = 13'h0101;
      5'h14: f = 13'h0121; 5'h15: f = 13'h0143; 5'h16: f = 13'h016A; 5'h17: f = 13'h0197;
      5'h18: f = 13'h01C8; 5'h19: f = 13'h0201; 5'h1A: f = 13'h0240; 5'h1B: f = 13'h0286;
      5'h1C: f = 13'h02D5; 5'h1D: f = 13'h032D; 5'h1E: f = 13'h0391; 5'h1F: f = `AR_GAIN_UNITY;
    endcase
    return f;
  endfunction : trim_factor

  function automatic logic [12:0] dac_factor(input logic [1:0] code);
    logic [12:0] f;
    f = `AR_GAIN_UNITY;
    unique case (code)
      2'b00: f = 13'h0400;
      2'b01: f = 13'h05A6;
      2'b10: f = 13'h07FB;
      2'b11: f = 13'h0B46;
    endcase
    return f;
  endfunction : dac_factor

  // Saturation keeps loud passages from wrapping to full-scale of the opposite sign.
  function automatic logic [SW-1:0] scale(input logic [SW-1:0] s, input logic [12:0] f);
    logic signed [SW+13:0] p;
    logic signed [SW+13:0] q;
    p = $signed({{14{s[SW-1]}}, s}) * $signed({{(SW+1){1'b0}}, f});
    q = p >>> `AR_GAIN_FRAC;
    if (q > $signed({{15{1'b0}}, {(SW-1){1'b1}}})) begin
      return {1'b0, {(SW-1){1'b1}}};
    end else if (q < -$signed({{14{1'b0}}, 1'b1, {(SW-1){1'b0}}})) begin
      return {1'b1, {(SW-1){1'b0}}};
    end
    return q[SW-1:0];
  endfunction : scale

  function automatic logic [SW-1:0] avg(input logic [SW-1:0] a, input logic [SW-1:0] b);
    logic [SW:0] s;
    s = {a[SW-1], a} + {b[SW-1], b};
    return s[SW:1];
  endfunction : avg

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [7:0] broadcast_level_trim;
  logic [7:0] error_lower_threshold;
  logic [7:0] error_upper_threshold;
  logic [7:0] output_mute_control;
  logic [7:0] dac_source_gain_select;
  logic [7:0] analog_output_select;
  logic [7:0] next_rdata;
  logic       wr_trim, wr_lower, wr_upper, wr_mute, wr_dac, wr_ana;

  assign wr_trim  = i_reg_wr && (i_reg_addr == `AR_OFS_LEVEL_TRIM);
  assign wr_lower = i_reg_wr && (i_reg_addr == `AR_OFS_ERR_LOWER);
  assign wr_upper = i_reg_wr && (i_reg_addr == `AR_OFS_ERR_UPPER);
  assign wr_mute  = i_reg_wr && (i_reg_addr == `AR_OFS_MUTE_CTRL);
  assign wr_dac   = i_reg_wr && (i_reg_addr == `AR_OFS_DAC_SELECT);
  assign wr_ana   = i_reg_wr && (i_reg_addr == `AR_OFS_ANALOG_SELECT);

  // Unmapped subaddresses read as zero and ignore writes.
  always_comb begin
    next_rdata = 8'h00;
    unique case (i_reg_addr)
      `AR_OFS_LEVEL_TRIM:    next_rdata = broadcast_level_trim;
      `AR_OFS_ERR_LOWER:     next_rdata = error_lower_threshold;
      `AR_OFS_ERR_UPPER:     next_rdata = error_upper_threshold;
      `AR_OFS_MUTE_CTRL:     next_rdata = output_mute_control;
      `AR_OFS_DAC_SELECT:    next_rdata = dac_source_gain_select;
      `AR_OFS_ANALOG_SELECT: next_rdata = analog_output_select;
      default:               next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      broadcast_level_trim   <= `AR_RST_LEVEL_TRIM;
      error_lower_threshold  <= `AR_RST_ERR_LOWER;
      error_upper_threshold  <= `AR_RST_ERR_UPPER;
      output_mute_control    <= `AR_RST_MUTE_CTRL;
      dac_source_gain_select <= `AR_RST_DAC_SELECT;
      analog_output_select   <= `AR_RST_ANALOG_SELECT;
      o_reg_rdata            <= 8'h00;
      o_reg_ack              <= 1'b0;
    end else begin
      if (wr_trim)  broadcast_level_trim   <= i_reg_wdata;
      if (wr_lower) error_lower_threshold  <= i_reg_wdata;
      if (wr_upper) error_upper_threshold  <= i_reg_wdata;
      if (wr_mute)  output_mute_control    <= i_reg_wdata;
      if (wr_dac)   dac_source_gain_select <= i_reg_wdata;
      if (wr_ana)   analog_output_select   <= i_reg_wdata;
      o_reg_rdata <= i_reg_rd ? next_rdata : o_reg_rdata;
      o_reg_ack   <= i_reg_wr || i_reg_rd;
    end
  end

  // --------------------------------------------------------------------------
  // Auto-mute selection
  // --------------------------------------------------------------------------
  automute_state_t am_state;
  automute_state_t next_am_state;
  logic            am_active;

  assign am_active = !i_auto_switch_disable && i_carrier2_digital;

  always_comb begin
    next_am_state = am_state;
    if (!am_active) begin
      next_am_state = SEL_BROADCAST;
    end else if (i_err_valid) begin
      unique case (am_state)
        SEL_BROADCAST: if (i_err_count > error_upper_threshold) next_am_state = SEL_FALLBACK;
        SEL_FALLBACK:  if (i_err_count < error_lower_threshold) next_am_state = SEL_BROADCAST;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Control decode
  // --------------------------------------------------------------------------
  analog_source_t ana_src;
  analog_source_t ana_src_eff;
  matrix_mode_t   matrix;
  logic           mono_fallback;
  logic           dac_silenced;
  logic [2:0]     next_analog_matrix;

  assign ana_src = analog_source_t'(analog_output_select[1:0]);
  assign matrix  = matrix_mode_t'(analog_output_select[`AR_MATRIX_MSB:`AR_MATRIX_LSB]);
  // Undefined source code 01 is treated as the DAC.
  assign mono_fallback = (am_state == SEL_FALLBACK) && i_fallback_source_pick && !ana_src[1];
  assign ana_src_eff   = mono_fallback ? ANA_SRC_MONO : (ana_src[1] ? ana_src : ANA_SRC_DAC);
  assign dac_silenced  = ana_src_eff[1];
  // The analog switch cannot average, so an analog input gets the straight pairing.
  assign next_analog_matrix = (dac_silenced && matrix == MATRIX_AVERAGE) ? MATRIX_STEREO : matrix;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      am_state             <= SEL_BROADCAST;
      o_analog_source      <= 2'h0;
      o_analog_matrix      <= 3'h0;
      o_dac_mute           <= 1'b1;
      o_serial_mute        <= 1'b1;
      o_analog_mute        <= 1'b1;
      o_broadcast_selected <= 1'b1;
    end else begin
      am_state             <= next_am_state;
      o_analog_source      <= ana_src_eff;
      o_analog_matrix      <= next_analog_matrix;
      o_dac_mute           <= dac_silenced;
      o_serial_mute        <= output_mute_control[`AR_MUTE_SERIAL_BIT];
      o_analog_mute        <= output_mute_control[`AR_MUTE_ANALOG_BIT];
      o_broadcast_selected <= (am_state == SEL_BROADCAST);
    end
  end

  // --------------------------------------------------------------------------
  // Sample processing stage
  // --------------------------------------------------------------------------
  logic          accept;
  logic          stage_valid, next_stage_valid;
  logic [SW-1:0] stage_ser_l, stage_ser_r, stage_dac_l, stage_dac_r;
  logic [SW-1:0] next_ser_l, next_ser_r, next_dac_l, next_dac_r;
  logic [SW-1:0] bc_l, bc_r, src_l, src_r, mx_l, mx_r;
  logic [12:0]   dgain;
  logic          fifo_in_ready;
  logic [CW-1:0] fifo_count;
  logic          fifo_out_valid, fifo_out_ready;
  logic [FW-1:0] fifo_out_data;
  logic          next_in_ready;

  assign accept = i_in_valid && o_in_ready;
  assign dgain  = dac_factor({dac_source_gain_select[`AR_DAC_GAIN_HI_BIT],
                              dac_source_gain_select[`AR_DAC_GAIN_LO_BIT]});

  always_comb begin
    bc_l = scale(i_in_bc_left, trim_factor(broadcast_level_trim[4:0]));
    bc_r = scale(i_in_bc_right, trim_factor(broadcast_level_trim[4:0]));
    if (am_state == SEL_FALLBACK) begin
      bc_l = i_in_fm_left;
      bc_r = i_in_fm_right;
    end
    // The serial pair never takes the analog mono input as fallback.
    next_ser_l = output_mute_control[`AR_MUTE_SERIAL_BIT] ? '0 : bc_l;
    next_ser_r = output_mute_control[`AR_MUTE_SERIAL_BIT] ? '0 : bc_r;
    src_l = i_in_fm_left;
    src_r = i_in_fm_right;
    unique case (dac_source_t'(dac_source_gain_select[1:0]))
      DAC_SRC_FM:    begin src_l = i_in_fm_left; src_r = i_in_fm_right; end
      DAC_SRC_BC:    begin src_l = bc_l;         src_r = bc_r;          end
      DAC_SRC_FM_M1: begin src_l = i_in_fm_left; src_r = bc_l;          end
      DAC_SRC_FM_M2: begin src_l = i_in_fm_left; src_r = bc_r;          end
    endcase
    mx_l = src_l;
    mx_r = src_r;
    case (matrix)
      MATRIX_LEFT:    begin mx_r = src_l; end
      MATRIX_RIGHT:   begin mx_l = src_r; end
      MATRIX_SWAP:    begin mx_l = src_r; mx_r = src_l; end
      MATRIX_AVERAGE: begin mx_l = avg(src_l, src_r); mx_r = mx_l; end
      default:        begin mx_l = src_l; mx_r = src_r; end
    endcase
    next_dac_l = (dac_silenced || output_mute_control[`AR_MUTE_ANALOG_BIT]) ? '0 : scale(mx_l, dgain);
    next_dac_r = (dac_silenced || output_mute_control[`AR_MUTE_ANALOG_BIT]) ? '0 : scale(mx_r, dgain);
    next_stage_valid = accept || (stage_valid && !fifo_in_ready);
  end

  // The ready margin covers the frames in flight between the count and the stage.
  assign next_in_ready = (fifo_count <= CW'(FIFO_DEPTH - 4));

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_valid <= 1'b0;
      stage_ser_l <= '0;
      stage_ser_r <= '0;
      stage_dac_l <= '0;
      stage_dac_r <= '0;
      o_in_ready  <= 1'b0;
    end else begin
      stage_valid <= next_stage_valid;
      o_in_ready  <= next_in_ready;
      if (accept) begin
        stage_ser_l <= next_ser_l;
        stage_ser_r <= next_ser_r;
        stage_dac_l <= next_dac_l;
        stage_dac_r <= next_dac_r;
      end
    end
  end

  sample_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (stage_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({stage_ser_l, stage_ser_r, stage_dac_l, stage_dac_r}),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data),
    .o_count     (fifo_count)
  );

  // --------------------------------------------------------------------------
  // Output register stage
  // --------------------------------------------------------------------------
  assign fifo_out_ready = !o_out_valid || i_out_ready;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_valid <= 1'b0;
      o_ser_left  <= '0;
      o_ser_right <= '0;
      o_dac_left  <= '0;
      o_dac_right <= '0;
    end else if (fifo_out_ready) begin
      o_out_valid <= fifo_out_valid;
      {o_ser_left, o_ser_right, o_dac_left, o_dac_right} <= fifo_out_data;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_fallback_on_upper: assert property (am_active && i_err_valid && am_state == SEL_BROADCAST &&
    i_err_count > error_upper_threshold |=> am_state == SEL_FALLBACK ##1 !o_broadcast_selected)
    else $error("auto-mute did not fall back above upper threshold");
  a_return_below_lower: assert property (am_active && i_err_valid && am_state == SEL_FALLBACK &&
    i_err_count < error_lower_threshold |=> am_state == SEL_BROADCAST)
    else $error("auto-mute did not return below lower threshold");
  a_hold_in_band: assert property (am_active && i_err_valid && i_err_count >= error_lower_threshold &&
    i_err_count <= error_upper_threshold |=> $stable(am_state))
    else $error("auto-mute changed inside hysteresis band");
  a_disabled_stays_bc: assert property (!am_active |=> am_state == SEL_BROADCAST ##1 o_broadcast_selected)
    else $error("auto-mute active while disabled");
  a_dac_auto_mute: assert property (accept && analog_output_select[1] |=> stage_dac_l == '0 &&
    stage_dac_r == '0 ##1 o_dac_mute || $past(wr_ana, 2))
    else $error("DAC not muted with analog input selected");
  a_no_avg_analog: assert property (o_analog_source[1] |-> o_analog_matrix != MATRIX_AVERAGE)
    else $error("average matrix offered for analog input");
  a_serial_fm_fb: assert property (accept && am_state == SEL_FALLBACK &&
    !output_mute_control[`AR_MUTE_SERIAL_BIT] |=> stage_ser_l == $past(i_in_fm_left))
    else $error("serial pair did not fall back to first carrier");
  a_serial_muted: assert property (accept && output_mute_control[`AR_MUTE_SERIAL_BIT]
    |=> stage_ser_l == '0 && stage_ser_r == '0)
    else $error("serial pair not muted");
  a_mono_fallback: assert property (am_state == SEL_FALLBACK && i_fallback_source_pick &&
    analog_output_select[1:0] == 2'b00 && !wr_ana |=> o_analog_source == ANA_SRC_MONO)
    else $error("mono fallback not selected");

  c_fallback:   cover property (am_state == SEL_BROADCAST ##1 am_state == SEL_FALLBACK);
  c_return:     cover property (am_state == SEL_FALLBACK ##1 am_state == SEL_BROADCAST);
  c_average:    cover property (accept && matrix == MATRIX_AVERAGE && !dac_silenced);
  c_stall_full: cover property (!o_in_ready && i_in_valid ##1 o_out_valid && !i_out_ready);

endmodule : audio_output_routing_control

`default_nettype wire

// File: hdl/audio_routing_params.svh
// Register offsets, field positions, reset values and gain constants of the audio output routing control.
`ifndef AUDIO_ROUTING_PARAMS_SVH
`define AUDIO_ROUTING_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (subaddresses)
// ----------------------------------------------------------------------------
`define AR_OFS_LEVEL_TRIM    8'h0F
`define AR_OFS_ERR_LOWER     8'h10
`define AR_OFS_ERR_UPPER     8'h11
`define AR_OFS_MUTE_CTRL     8'h12
`define AR_OFS_DAC_SELECT    8'h13
`define AR_OFS_ANALOG_SELECT 8'h14

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AR_RST_LEVEL_TRIM    8'h00
`define AR_RST_ERR_LOWER     8'h14
`define AR_RST_ERR_UPPER     8'h50
`define AR_RST_MUTE_CTRL     8'hFF
`define AR_RST_DAC_SELECT    8'h00
`define AR_RST_ANALOG_SELECT 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AR_TRIM_ATTEN_BIT    4
`define AR_MUTE_SERIAL_BIT   6
`define AR_MUTE_ANALOG_BIT   2
`define AR_DAC_GAIN_HI_BIT   7
`define AR_DAC_GAIN_LO_BIT   3
`define AR_MATRIX_MSB        6
`define AR_MATRIX_LSB        4

// ----------------------------------------------------------------------------
// Gain arithmetic: factors are unsigned with 10 fraction bits
// ----------------------------------------------------------------------------
`define AR_GAIN_FRAC         10
`define AR_GAIN_UNITY        13'h0400

`endif

// File: hdl/audio_routing_pkg.sv
// Types shared by the audio output routing control.
`default_nettype none

package audio_routing_pkg;

  typedef enum logic [2:0] {
    MATRIX_STEREO  = 3'b000,
    MATRIX_LEFT    = 3'b001,
    MATRIX_RIGHT   = 3'b010,
    MATRIX_SWAP    = 3'b011,
    MATRIX_AVERAGE = 3'b100
  } matrix_mode_t;

  typedef enum logic [1:0] {
    DAC_SRC_FM     = 2'b00,
    DAC_SRC_BC     = 2'b01,
    DAC_SRC_FM_M1  = 2'b10,
    DAC_SRC_FM_M2  = 2'b11
  } dac_source_t;

  typedef enum logic [1:0] {
    ANA_SRC_DAC    = 2'b00,
    ANA_SRC_UNDEF  = 2'b01,
    ANA_SRC_EXT    = 2'b10,
    ANA_SRC_MONO   = 2'b11
  } analog_source_t;

  typedef enum logic {
    SEL_BROADCAST  = 1'b0,
    SEL_FALLBACK   = 1'b1
  } automute_state_t;

endpackage : audio_routing_pkg

`default_nettype wire

// File: hdl/sample_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a fill count.
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data,
  // Fill level
  output logic [CW-1:0]         o_count
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count != CW'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign o_count     = count;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage has no reset; a word is only read after it was written.
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

endmodule : sample_fifo

`default_nettype wire

// File: tb/audio_sink.sv
// Output sample sink model that can stall the routing control's output stream.
`default_nettype none

module audio_sink (
  // Clock and stall request
  input  wire logic i_mclk,
  input  wire logic i_stall,
  // Handshake towards the block
  output logic      o_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // Ready follows the stall request one edge late, as a registered sink would.
  always_ff @(posedge i_mclk) begin
    o_ready <= !i_stall;
  end
endmodule : audio_sink

`default_nettype wire

// File: tb/audio_output_routing_control_tb.sv
// Register, auto-mute and stream bench for the audio output routing control.
`default_nettype none

module audio_output_routing_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'h0, i_rst_n = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0, i_err_valid = 1'h0, i_in_valid = 1'h0;
  logic i_auto_switch_disable = 1'h0, i_fallback_source_pick = 1'h0, i_carrier2_digital = 1'h1, stall = 1'h1;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_err_count = 8'h00, o_reg_rdata;
  logic [15:0] i_in_fm_left = 16'h1111, i_in_fm_right = 16'h2222, i_in_bc_left = 16'h0333, i_in_bc_right = 16'h0444;
  logic [15:0] o_ser_left, o_ser_right, o_dac_left, o_dac_right;
  logic o_reg_ack, o_in_ready, o_out_valid, i_out_ready, o_dac_mute, o_serial_mute, o_analog_mute, o_broadcast_selected;
  logic [1:0] o_analog_source;
  logic [2:0] o_analog_matrix;
  logic [7:0] rst_v [6] = '{8'h00, 8'h14, 8'h50, 8'hFF, 8'h00, 8'h00};
  logic [7:0] wv [6] = '{8'h1E, 8'h33, 8'h77, 8'hBB, 8'h8B, 8'h43};
  logic [15:0] dl [4] = '{16'h1111, 16'h0333, 16'h1111, 16'h1111};
  logic [15:0] dr [4] = '{16'h2222, 16'h0444, 16'h0333, 16'h0444};
  int err_total = 0, comparisons = 0, n_in = 0, n_out = 0, i;

  audio_output_routing_control DUT (.i_mclk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .o_reg_ack, .i_err_valid, .i_err_count, .i_auto_switch_disable, .i_fallback_source_pick, .i_carrier2_digital,
    .i_in_valid, .o_in_ready, .i_in_fm_left, .i_in_fm_right, .i_in_bc_left, .i_in_bc_right, .o_out_valid,
    .i_out_ready, .o_ser_left, .o_ser_right, .o_dac_left, .o_dac_right, .o_analog_source, .o_analog_matrix,
    .o_dac_mute, .o_serial_mute, .o_analog_mute, .o_broadcast_selected);
  audio_sink sink (.i_mclk, .i_stall(stall), .o_ready(i_out_ready));

  always #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    n_in <= n_in + int'(i_in_valid && o_in_ready);
    n_out <= n_out + int'(o_out_valid && i_out_ready);
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait; a hang counts as a mismatch and ends the run.
  task automatic await(ref logic s);
    int k;
    for (k = 0; k < 64; k++) begin
      #1;
      if (s === 1'h1) break;
      @(posedge i_mclk);
    end
    if (k == 64) begin
      err_total++;
      final_report();
    end
  endtask : await

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_wr <= w;
    i_reg_rd <= !w;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'h0;
    i_reg_rd <= 1'h0;
    await(o_reg_ack);
    @(posedge i_mclk);
    #1;
  endtask : xfer

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'h0, a, 8'h00);
    check(o_reg_rdata, e);
  endtask : rchk

  task automatic err(input logic [7:0] v);
    @(posedge i_mclk);
    i_err_valid <= 1'h1;
    i_err_count <= v;
    @(posedge i_mclk);
    i_err_valid <= 1'h0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask : err

  task automatic frame();
    @(posedge i_mclk);
    i_in_valid <= 1'h1;
    @(posedge i_mclk);
    i_in_valid <= 1'h0;
    await(o_out_valid);
  endtask : frame

  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    for (i = 0; i < 6; i++) rchk(8'(8'h0F + i), rst_v[i]);
    rchk(8'h15, 8'h00);
    for (i = 0; i < 6; i++) xfer(1'h1, 8'(8'h0F + i), wv[i]);
    for (i = 0; i < 6; i++) rchk(8'(8'h0F + i), wv[i]);
    for (i = 0; i < 6; i++) xfer(1'h1, 8'(8'h0F + i), rst_v[i]);
    xfer(1'h1, 8'h12, 8'hFB);
    check({o_serial_mute, o_analog_mute}, 2'h2);
    xfer(1'h1, 8'h14, 8'h42);
    check({o_analog_source, o_dac_mute, 1'(o_analog_matrix == 3'h4)}, 4'hA);
    xfer(1'h1, 8'h14, 8'h23);
    check({o_analog_source, o_dac_mute, o_analog_matrix}, 6'h3A);
    xfer(1'h1, 8'h14, 8'h40);
    check({o_analog_source, o_dac_mute, o_analog_matrix}, 6'h04);
    xfer(1'h1, 8'h14, 8'h00);
    xfer(1'h1, 8'h12, 8'hBB);
    check({o_serial_mute, o_analog_mute}, 2'h0);
    @(posedge i_mclk) stall <= 1'h0;
    for (i = 0; i < 4; i++) begin
      xfer(1'h1, 8'h13, 8'(i));
      frame();
      check({o_dac_left, o_dac_right, o_ser_left}, {dl[i], dr[i], 16'h0333});
    end
    xfer(1'h1, 8'h0F, 8'h14);
    xfer(1'h1, 8'h13, 8'h88);
    xfer(1'h1, 8'h14, 8'h30);
    frame();
    check({o_dac_left, o_dac_right, o_ser_left}, {16'h6032, 16'h3019, 16'h00E7});
    xfer(1'h1, 8'h13, 8'h00);
    xfer(1'h1, 8'h14, 8'h40);
    frame();
    check({o_dac_left, o_dac_right}, 32'h19991999);
    xfer(1'h1, 8'h14, 8'h02);
    frame();
    check({o_dac_left, o_dac_right, o_ser_left}, {32'h0, 16'h00E7});
    xfer(1'h1, 8'h14, 8'h00);
    err(8'h51);
    check(o_broadcast_selected, 1'h0);
    frame();
    check({o_ser_left, o_dac_left}, 32'h11111111);
    err(8'h50);
    check(o_broadcast_selected, 1'h0);
    err(8'h14);
    check(o_broadcast_selected, 1'h0);
    err(8'h13);
    check(o_broadcast_selected, 1'h1);
    @(posedge i_mclk) i_fallback_source_pick <= 1'h1;
    err(8'h51);
    check({o_analog_source, o_dac_mute}, 3'h7);
    @(posedge i_mclk) i_auto_switch_disable <= 1'h1;
    err(8'h51);
    check(o_broadcast_selected, 1'h1);
    @(posedge i_mclk) i_auto_switch_disable <= 1'h0;
    i_carrier2_digital <= 1'h0;
    err(8'h51);
    check(o_broadcast_selected, 1'h1);
    @(posedge i_mclk) stall <= 1'h1;
    i_in_valid <= 1'h1;
    repeat (40) @(posedge i_mclk);
    #1;
    check({o_in_ready, o_out_valid}, 2'h1);
    @(posedge i_mclk) i_in_valid <= 1'h0;
    stall <= 1'h0;
    repeat (40) @(posedge i_mclk);
    #1;
    check({32'(n_in - n_out), 1'(o_out_valid)}, 33'h0);
    final_report();
  end
endmodule : audio_output_routing_control_tb

`default_nettype wire
